// [dpm_pkg.sv]
// constants and carrier types for the code-point priority map slice
package dpm_pkg;
   localparam int          REG_CNT     = 8;
   localparam int          FIELD_W     = 2;
   localparam int          FIELDS_REG  = 4;
   localparam int          CODE_W      = 6;
   localparam int          CODE_CNT    = 64;
   localparam int          TABLE_BITS  = 128;
   localparam int          TOS_MSB     = 7;
   localparam int          TOS_LSB     = 2;
   localparam logic [5:0]  CODE_FIRST  = 6'h08;
   localparam logic [5:0]  CODE_LAST   = 6'h27;
   localparam logic [7:0]  OFF_08_0B   = 8'h62;
   localparam logic [7:0]  OFF_0C_0F   = 8'h63;
   localparam logic [7:0]  OFF_10_13   = 8'h64;
   localparam logic [7:0]  OFF_14_17   = 8'h65;
   localparam logic [7:0]  OFF_18_1B   = 8'h66;
   localparam logic [7:0]  OFF_1C_1F   = 8'h67;
   localparam logic [7:0]  OFF_20_23   = 8'h68;
   localparam logic [7:0]  OFF_24_27   = 8'h69;
   localparam logic [7:0]  REG_RESET   = 8'h00;

   // register access request from the switch register interface
   typedef struct packed {
      logic       wrEn;
      logic       rdEn;
      logic [7:0] addr;
      logic [7:0] wrData;
   } dpm_reg_req_t;

   // frame header summary presented for classification
   typedef struct packed {
      logic       valid;
      logic       isIp;
      logic [7:0] tos;
   } dpm_frame_t;

   // classification result
   typedef struct packed {
      logic       valid;
      logic       hit;
      logic [1:0] prio;
   } dpm_result_t;
endpackage

// [dpm_code_decode.sv]
// full one-of-64 decode of a code point
`timescale 1ns/1ps
module dpm_code_decode
#(
   parameter int CODE_W = 6
)
(
   input  wire logic [CODE_W-1:0]      code,
   output wire logic [(1<<CODE_W)-1:0] oneHot
);
   genvar i;
   generate
      for (i = 0; i < (1 << CODE_W); i++)
      begin : g_dec
         assign oneHot[i] = (code == CODE_W'(i));
      end
   endgenerate
endmodule

// [dpm_prio_map.sv]
// code-point priority map slice: eight map registers and the frame lookup
// Function
// - lookup key is bits 7:2 of the ToS / traffic-class byte, six bits
// - frame priority is the 2-bit field selected by its code point
// - offset 0x62 holds codes 0x08..0x0B, low code in bits 1:0, reset 00
// - offset 0x63 holds codes 0x0C..0x0F, low code in bits 1:0, reset 00
// - offset 0x64 holds codes 0x10..0x13, low code in bits 1:0, reset 00
// - offset 0x65 holds codes 0x14..0x17, low code in bits 1:0, reset 00
// - offset 0x66 holds codes 0x18..0x1B, low code in bits 1:0, reset 00
// - offset 0x67 holds codes 0x1C..0x1F, low code in bits 1:0, reset 00
// - offset 0x68 holds codes 0x20..0x23, low code in bits 1:0, reset 00
// - offset 0x69 holds codes 0x24..0x27, low code in bits 1:0, reset 00
// - code point fully decoded to 64 selections, one field chosen for codes 0x08..0x27
// - whole table is 128 bits; this slice serves codes 0x08..0x27
`timescale 1ns/1ps
module dpm_prio_map
   import dpm_pkg::*;
(
   input  wire logic               core_clk,
   input  wire logic               rst_n,
   input  wire logic               clkEn,
   input  wire dpm_pkg::dpm_reg_req_t regReq,
   output logic [7:0]              regRdData,
   output logic                    regRdValid,
   output logic                    regRdHit,
   input  wire dpm_pkg::dpm_frame_t frmIn,
   output dpm_pkg::dpm_result_t    prioOut
);
   import dpm_pkg::*;

   logic [7:0]              mapRegs_ff [REG_CNT];
   logic [7:0]              regRdData_ff;
   logic                    regRdValid_ff;
   logic                    regRdHit_ff;
   dpm_result_t             prioOut_ff;
   dpm_result_t             nxt_prioOut;

   wire  [7:0]              addrOff;
   wire  [2:0]              regIdx;
   wire                     addrHit;
   wire                     wrHit;
   wire                     rdAcc;
   wire  [5:0]              frmCode;
   wire  [CODE_CNT-1:0]     codeSel;
   wire  [REG_CNT*8-1:0]    sliceFlat;
   wire  [FIELD_W-1:0]      fieldPick [REG_CNT*FIELDS_REG];
   wire  [FIELD_W-1:0]      fieldOr   [REG_CNT*FIELDS_REG+1];
   wire                     codeInSlice;
   wire                     frmTake;

   // register address decode
   assign addrOff = regReq.addr - OFF_08_0B;
   assign regIdx  = addrOff[2:0];
   assign addrHit = (regReq.addr >= OFF_08_0B) && (regReq.addr <= OFF_24_27);
   assign wrHit   = clkEn && regReq.wrEn && addrHit;
   assign rdAcc   = clkEn && regReq.rdEn;

   // map registers, one byte each, four 2-bit fields low code first
   genvar r;
   generate
      for (r = 0; r < REG_CNT; r++)
      begin : g_reg
         always_ff @(posedge core_clk or negedge rst_n)
         begin
            if (!rst_n)
               mapRegs_ff[r] <= REG_RESET;
            else if (wrHit && (regIdx == 3'(r)))
               mapRegs_ff[r] <= regReq.wrData;
         end
         assign sliceFlat[r*8 +: 8] = mapRegs_ff[r];
      end
   endgenerate

   // read port, unmapped offsets read as zero with hit low
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         regRdData_ff  <= 8'h00;
         regRdValid_ff <= 1'b0;
         regRdHit_ff   <= 1'b0;
      end
      else if (clkEn)
      begin
         regRdValid_ff <= regReq.rdEn;
         regRdHit_ff   <= regReq.rdEn && addrHit;
         if (regReq.rdEn)
            regRdData_ff <= addrHit ? mapRegs_ff[regIdx] : 8'h00;
      end
   end

   assign regRdData  = regRdData_ff;
   assign regRdValid = regRdValid_ff;
   assign regRdHit   = regRdHit_ff;

   // frame key and full decode
   assign frmCode = frmIn.tos[TOS_MSB:TOS_LSB];

   dpm_code_decode #(
      .CODE_W (CODE_W)
   ) u_decode (
      .code   (frmCode),
      .oneHot (codeSel)
   );

   // each field of the slice is gated by its own decode line
   genvar f;
   generate
      assign fieldOr[0] = '0;
      for (f = 0; f < REG_CNT*FIELDS_REG; f++)
      begin : g_field
         assign fieldPick[f] = codeSel[f + CODE_FIRST] ?
                               sliceFlat[f*FIELD_W +: FIELD_W] : '0;
         assign fieldOr[f+1] = fieldOr[f] | fieldPick[f];
      end
   endgenerate

   // slice covers 32 of the 128 table bits' code points
   assign codeInSlice = |codeSel[CODE_LAST:CODE_FIRST];
   assign frmTake     = frmIn.valid && frmIn.isIp;

   always_comb
   begin
      nxt_prioOut       = '0;
      nxt_prioOut.valid = frmTake;
      nxt_prioOut.hit   = frmTake && codeInSlice;
      if (frmTake && codeInSlice)
         nxt_prioOut.prio = fieldOr[REG_CNT*FIELDS_REG];
   end

   // result registered; lookup sees only writes completed before it
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         prioOut_ff <= '0;
      else if (clkEn)
         prioOut_ff <= nxt_prioOut;
   end

   assign prioOut = prioOut_ff;

   // checks
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);

   wire [5:0] chkRel;
   wire [1:0] chkExp;
   assign chkRel = frmCode - CODE_FIRST;
   assign chkExp = sliceFlat[{chkRel[4:0], 1'b0} +: 2];

   sequence s_ipFrame;
      clkEn && frmIn.valid && frmIn.isIp;
   endsequence

   sequence s_sliceFrame;
      s_ipFrame ##0 (frmCode >= CODE_FIRST) && (frmCode <= CODE_LAST);
   endsequence

   // write taken, then a frame whose field sits in the written register
   sequence s_wrThenFrame;
      wrHit ##1 s_sliceFrame ##0 (chkRel[4:2] == $past(regIdx));
   endsequence

   property p_regWrite(logic [7:0] off, int idx);
      clkEn && regReq.wrEn && (regReq.addr == off)
         |=> (mapRegs_ff[idx] == $past(regReq.wrData));
   endproperty

   a_key_bits: assert property (
      s_ipFrame |=> prioOut.valid && (prioOut.hit == $past(codeInSlice)))
      else $error("lookup key not taken from tos bits 7:2");

   a_prio_select: assert property (
      s_sliceFrame |=> prioOut.hit && (prioOut.prio == $past(chkExp)))
      else $error("frame priority differs from selected field");

   a_reg62_write: assert property (p_regWrite(OFF_08_0B, 0))
      else $error("write to 0x62 not stored");
   a_reg63_write: assert property (p_regWrite(OFF_0C_0F, 1))
      else $error("write to 0x63 not stored");
   a_reg64_write: assert property (p_regWrite(OFF_10_13, 2))
      else $error("write to 0x64 not stored");
   a_reg65_write: assert property (p_regWrite(OFF_14_17, 3))
      else $error("write to 0x65 not stored");
   a_reg66_write: assert property (p_regWrite(OFF_18_1B, 4))
      else $error("write to 0x66 not stored");
   a_reg67_write: assert property (p_regWrite(OFF_1C_1F, 5))
      else $error("write to 0x67 not stored");
   a_reg68_write: assert property (p_regWrite(OFF_20_23, 6))
      else $error("write to 0x68 not stored");
   a_reg69_write: assert property (p_regWrite(OFF_24_27, 7))
      else $error("write to 0x69 not stored");

   a_decode_onehot: assert property ($onehot(codeSel))
      else $error("code decode not one-hot");

   a_slice_outside: assert property (
      s_ipFrame ##0 ((frmCode < CODE_FIRST) || (frmCode > CODE_LAST))
         |=> !prioOut.hit && (prioOut.prio == 2'b00))
      else $error("code outside slice produced a hit");

   a_read_last: assert property (
      rdAcc && addrHit |=> regRdValid && regRdHit
         && (regRdData == $past(mapRegs_ff[regIdx])))
      else $error("read does not return stored value");

   a_write_then_use: assert property (
      s_wrThenFrame
         |=> prioOut.prio == 2'($past(regReq.wrData, 2) >> {$past(chkRel[1:0]), 1'b0}))
      else $error("lookup after write did not use new value");

   a_read_unmapped: assert property (
      rdAcc && !addrHit |=> regRdValid && !regRdHit && (regRdData == 8'h00))
      else $error("unmapped read returned data or hit");

   a_nonip_silent: assert property (
      clkEn && !(frmIn.valid && frmIn.isIp) |=> !prioOut.valid && !prioOut.hit)
      else $error("non-ip frame produced a result");

   a_freeze_hold: assert property (
      !clkEn |=> $stable(prioOut) && $stable(regRdData) && $stable(regRdValid)
         && $stable(regRdHit))
      else $error("state moved while clock enable low");

endmodule

// [dpm_prio_map_tb_top.sv]
// self-checking testbench for the code-point priority map slice
`timescale 1ns/1ps
module dpm_prio_map_tb_top;
   import dpm_pkg::*;
   logic         core_clk;
   logic         rst_n;
   logic         clkEn;
   dpm_reg_req_t regReq;
   logic [7:0]   regRdData;
   logic         regRdValid;
   logic         regRdHit;
   dpm_frame_t   frmIn;
   dpm_result_t  prioOut;
   logic [7:0]   mdl [REG_CNT];
   logic [3:0]   ex;
   int           err_count;
   int           cmp_count;
   int           cyc;

   dpm_prio_map dut_u (.core_clk(core_clk), .rst_n(rst_n), .clkEn(clkEn), .regReq(regReq),
      .regRdData(regRdData), .regRdValid(regRdValid), .regRdHit(regRdHit), .frmIn(frmIn),
      .prioOut(prioOut));

   initial
   begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end

   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   always @(posedge core_clk)
   begin
      cyc++;
      if (cyc == 4000)
      begin
         err_count++;
         wrap_up();
      end
   end

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         err_count++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   // expected {valid, hit, prio} from the model table
   function automatic logic [3:0] expRes(input logic [5:0] code, input logic ip);
      int idx;
      idx = int'(code) - 8;
      if (!ip)
         return 4'h0;
      if (code < CODE_FIRST || code > CODE_LAST)
         return 4'h8;
      return {2'b11, mdl[idx / 4][2 * (idx % 4) +: 2]};
   endfunction

   // request stays up until the next task replaces it, so no strobe is set twice in a step
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      regReq = {1'b1, 1'b0, a, d};
      @(negedge core_clk);
      if (a >= OFF_08_0B && a <= OFF_24_27)
         mdl[int'(a - OFF_08_0B)] = d;
   endtask

   task automatic rd(input logic [7:0] a);
      logic hit;
      hit = (a >= OFF_08_0B && a <= OFF_24_27);
      regReq = {1'b0, 1'b1, a, 8'h00};
      @(negedge core_clk);
      chk("regRdValid", 8'h01, {7'h00, regRdValid});
      chk("regRdHit", {7'h00, hit}, {7'h00, regRdHit});
      chk("regRdData", hit ? mdl[int'(a - OFF_08_0B)] : 8'h00, regRdData);
   endtask

   task automatic frm(input logic [7:0] tos, input logic ip);
      frmIn = {1'b1, ip, tos};
      ex = expRes(tos[TOS_MSB:TOS_LSB], ip);
      @(negedge core_clk);
      chk("prioOut", {4'h0, ex}, {4'h0, prioOut});
   endtask

   // drop all requests for one edge; read valid and result must fall
   task automatic idle;
      regReq = '0;
      frmIn = '0;
      @(negedge core_clk);
      chk("regRdValid", 8'h00, {7'h00, regRdValid});
      chk("prioOut", 8'h00, {4'h0, prioOut});
   endtask

   task automatic rstAll;
      for (int i = 0; i < REG_CNT; i++)
         mdl[i] = REG_RESET;
   endtask

   initial
   begin
      rst_n = 1'b0;
      clkEn = 1'b1;
      regReq = '0;
      frmIn = '0;
      rstAll();
      void'($urandom(6));
      repeat (16) @(negedge core_clk);
      chk("prioOut", 8'h00, {4'h0, prioOut});
      rst_n = 1'b1;
      for (int i = 0; i < REG_CNT; i++) rd(OFF_08_0B + 8'(i));
      wr(8'h6A, 8'hFF);
      rd(8'h61);
      rd(8'h6A);
      rd(OFF_08_0B);
      wr(OFF_08_0B, 8'hE4);
      rd(OFF_08_0B);
      for (int r = 0; r < 3; r++)
      begin
         for (int i = 0; i < REG_CNT; i++) wr(OFF_08_0B + 8'(i), 8'($urandom));
         for (int i = 0; i < REG_CNT; i++) rd(OFF_08_0B + 8'(i));
         for (int c = 0; c < CODE_CNT; c++) frm({6'(c), 2'($urandom)}, 1'b1);
      end
      for (int i = 0; i < 4; i++) frm(8'($urandom), 1'b0);
      // write in the same cycle as a frame: frame still sees the old field
      regReq = {1'b1, 1'b0, OFF_08_0B, ~mdl[0]};
      frmIn = {2'b11, 6'h09, 2'b01};
      ex = expRes(6'h09, 1'b1);
      @(negedge core_clk);
      mdl[0] = ~mdl[0];
      chk("prioOut", {4'h0, ex}, {4'h0, prioOut});
      frm({6'h09, 2'b10}, 1'b1);
      // read and write of one offset in one cycle: read gives the old byte
      regReq = {1'b1, 1'b1, OFF_10_13, ~mdl[2]};
      @(negedge core_clk);
      chk("regRdData", mdl[2], regRdData);
      mdl[2] = ~mdl[2];
      rd(OFF_10_13);
      // write while the clock enable is low is dropped
      clkEn = 1'b0;
      regReq = {1'b1, 1'b0, OFF_0C_0F, ~mdl[1]};
      @(negedge core_clk);
      clkEn = 1'b1;
      idle();
      rd(OFF_0C_0F);
      rst_n = 1'b0;
      @(negedge core_clk);
      chk("regRdValid", 8'h00, {7'h00, regRdValid});
      chk("prioOut", 8'h00, {4'h0, prioOut});
      rst_n = 1'b1;
      rstAll();
      for (int i = 0; i < REG_CNT; i++) rd(OFF_08_0B + 8'(i));
      frm({6'h27, 2'b11}, 1'b1);
      wrap_up();
   end
endmodule
